// ### logic/fakg_glue.sv
// Fast A20 / alternate reset port, controller pin glue and keyboard/mouse wake
// Functional notes
// - Fast port answers reads and writes only while config bit 2 is set.
// - Fast port reads return fixed 0,0,1,0,0,1 in bits 7 down to 2.
// - Fast port bit 1 sets alternate A20 gate to the written level.
// - Writing 1 to bit 0 pulses alternate reset low 6us after 14us.
// - Short 1us/500ns figures are covered by the longer 6us/14us timing.
// - New reset pulse only after bit 0 returns to 0 by reset or write.
// - Reset clears bit 0 and holds alternate reset high.
// - Keyboard reset out is fast pulse AND controller reset while bit 2 is set, else controller reset alone, with GPIO polarity.
// - A20 mask low only when controller A20 bit and alternate gate are 0.
// - Reset drives alternate A20 gate low.
// - Push-pull: 0 drives low, 1 drives high for 500ns then pull-up only.
// - Open-drain: 0 drives low, 1 floats the pin.
// - Controller mode pins ignore GPIO input or invert settings.
// - Bit 4 selects mouse irq: raw AND latched, or latched alone.
// - Bit 3 selects keyboard irq: raw AND latched, or latched alone.
// - Data line active edges set keyboard and mouse wake status bits.
// - Wake request needs both source enable and global enable.
// - Bit 6 blocks mouse clock and data into controller, not into wake logic.
// - Bit 5 blocks keyboard clock and data into controller, not into wake logic.
// - Register 0x2C bit 6 holds controller in reset and never self-clears.
// - Active wake edge is the high-to-low data transition.
// - Wake status sets regardless of the global enable.
`timescale 1ns/1ps
`default_nettype none
module fakg_glue
  import fakg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Host I/O bus pins
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd_n,
  input  wire logic        io_wr_n,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rdata_oe,
  // Configuration register access, same clock
  input  wire logic [7:0]  cfg_index,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  // Keyboard controller core signals
  input  wire logic        kbc_cpu_reset_n,
  input  wire logic        kbc_a20_port_bit,
  input  wire logic        kbc_kbd_irq_raw,
  input  wire logic        kbc_mouse_irq_raw,
  input  wire logic        kbc_kbd_irq_clr,
  input  wire logic        kbc_mouse_irq_clr,
  input  wire logic [2:0]  kbc_out_bits,
  input  wire logic [2:0]  kbc_out_open_drain,
  input  wire logic        gpio_polarity_inv,
  output logic             kbc_hold_reset,
  output logic             kbc_kbd_clock_in,
  output logic             kbc_kbd_data_in,
  output logic             kbc_mouse_clock_in,
  output logic             kbc_mouse_data_in,
  // System outputs
  output logic             alt_cpu_reset_n,
  output logic             gate_a,
  output logic             cpu_a20_mask_n,
  output logic             kbd_reset_out,
  output logic             kbd_irq,
  output logic             mouse_irq,
  // Controller port pins a, b, c
  output logic      [2:0]  kbc_out_pin,
  output logic      [2:0]  kbc_out_pin_oe,
  // Keyboard and mouse lines
  input  wire logic        kbd_clock_line,
  input  wire logic        kbd_data_line,
  input  wire logic        mouse_clock_line,
  input  wire logic        mouse_data_line,
  // Wake logic
  input  wire logic        kbd_wake_en,
  input  wire logic        mouse_wake_en,
  input  wire logic        wake_global_enable,
  input  wire logic        kbd_wake_sts_clr,
  input  wire logic        mouse_wake_sts_clr,
  output logic             kbd_wake_sts,
  output logic             mouse_wake_sts,
  output logic             wake_req
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [15:0] addr_s;
  logic [7:0]  wdata_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic        wr_n_q;
  logic        kck_s;
  logic        kdt_s;
  logic        mck_s;
  logic        mdt_s;

  // Strobes and lines come out of reset at their idle high level
  fakg_sync2 #(.W(26), .RST_VAL(26'h0000003)) u_sync_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_async ({io_addr, io_wdata, io_rd_n, io_wr_n}),
    .d_sync  ({addr_s, wdata_s, rd_n_s, wr_n_s})
  );

  fakg_sync2 #(.W(4), .RST_VAL(4'hf)) u_sync_lines (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_async ({kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line}),
    .d_sync  ({kck_s, kdt_s, mck_s, mdt_s})
  );

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [7:0] kra_q;
  logic [7:0] glb2c_q;
  logic       port_en;

  assign port_en = kra_q[KRA_PORT_EN_BIT];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kra_q   <= KRA_RESET_VAL;
      glb2c_q <= GLB2C_RESET_VAL;
    end else if (cfg_wr) begin
      if (cfg_index == CFG_IDX_KRA) begin
        kra_q <= cfg_wdata;
      end else if (cfg_index == CFG_IDX_GLB2C) begin
        glb2c_q <= cfg_wdata;
      end
    end
  end

  always_comb begin
    if (cfg_index == CFG_IDX_KRA) begin
      cfg_rdata = kra_q;
    end else if (cfg_index == CFG_IDX_GLB2C) begin
      cfg_rdata = glb2c_q;
    end else begin
      cfg_rdata = 8'h00;
    end
  end

  // Held until software writes it back to 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kbc_hold_reset <= 1'b0;
    end else begin
      kbc_hold_reset <= glb2c_q[GLB_KBC_RST_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Fast port
  // ------------------------------------------------------------------
  logic fp_hit;
  logic fp_wr;
  logic rst_bit_q;
  logic a20_bit_q;
  logic rst_trig;

  assign fp_hit   = (addr_s == FAST_PORT_ADDR) && port_en;
  // Act once on the leading edge of the write strobe
  assign fp_wr    = fp_hit && !wr_n_s && wr_n_q;
  assign rst_trig = fp_wr && wdata_s[FP_RST_BIT] && !rst_bit_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_q <= 1'b1;
    end else begin
      wr_n_q <= wr_n_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_bit_q <= FP_RESET_VAL[FP_RST_BIT];
      a20_bit_q <= FP_RESET_VAL[FP_A20_BIT];
    end else if (fp_wr) begin
      rst_bit_q <= wdata_s[FP_RST_BIT];
      a20_bit_q <= wdata_s[FP_A20_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata    <= 8'h00;
      io_rdata_oe <= 1'b0;
    end else begin
      io_rdata    <= FP_FIXED_VAL | {6'h00, a20_bit_q, rst_bit_q};
      io_rdata_oe <= fp_hit && !rd_n_s;
    end
  end

  // ------------------------------------------------------------------
  // Alternate reset sequencer
  // ------------------------------------------------------------------
  // The longer delay and pulse also satisfy the short 500ns/1us figures
  fakg_rst_state_e st_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= FAKG_ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        FAKG_ST_IDLE: begin
          if (rst_trig) begin
            st_q  <= FAKG_ST_DELAY;
            cnt_q <= CNT_W'(ALT_RST_DELAY_CYC - 1);
          end
        end
        FAKG_ST_DELAY: begin
          if (cnt_q == '0) begin
            st_q  <= FAKG_ST_PULSE;
            cnt_q <= CNT_W'(ALT_RST_PULSE_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FAKG_ST_PULSE: begin
          if (cnt_q == '0) begin
            st_q <= FAKG_ST_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FAKG_ST_DONE: begin
          // Rearm only once bit 0 has gone back to 0
          if (!rst_bit_q) begin
            st_q <= FAKG_ST_IDLE;
          end
        end
        default: begin
          st_q <= FAKG_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // System outputs
  // ------------------------------------------------------------------
  logic comb_rst_n;

  always_comb begin
    if (port_en) begin
      comb_rst_n = alt_cpu_reset_n & kbc_cpu_reset_n;
    end else begin
      comb_rst_n = kbc_cpu_reset_n;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alt_cpu_reset_n <= 1'b1;
      gate_a          <= 1'b0;
      cpu_a20_mask_n  <= 1'b0;
      kbd_reset_out   <= 1'b1;
    end else begin
      alt_cpu_reset_n <= (st_q != FAKG_ST_PULSE);
      gate_a          <= a20_bit_q;
      cpu_a20_mask_n  <= kbc_a20_port_bit | a20_bit_q;
      kbd_reset_out   <= comb_rst_n ^ gpio_polarity_inv;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt latches
  // ------------------------------------------------------------------
  logic kirq_lat_q;
  logic mirq_lat_q;

  // Latch sets on the raw request and holds until the controller clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kirq_lat_q <= 1'b0;
      mirq_lat_q <= 1'b0;
    end else begin
      kirq_lat_q <= kbc_kbd_irq_raw | (kirq_lat_q & ~kbc_kbd_irq_clr);
      mirq_lat_q <= kbc_mouse_irq_raw | (mirq_lat_q & ~kbc_mouse_irq_clr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kbd_irq   <= 1'b0;
      mouse_irq <= 1'b0;
    end else begin
      kbd_irq   <= kra_q[KRA_KLSEL_BIT]  ? kirq_lat_q
                                         : (kbc_kbd_irq_raw & kirq_lat_q);
      mouse_irq <= kra_q[KRA_MLSEL_BIT]  ? mirq_lat_q
                                         : (kbc_mouse_irq_raw & mirq_lat_q);
    end
  end

  // ------------------------------------------------------------------
  // Controller port pins
  // ------------------------------------------------------------------
  // GPIO input and invert settings are not wired here at all
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      fakg_pin_drv u_drv (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .port_bit   (kbc_out_bits[gi]),
        .open_drain (kbc_out_open_drain[gi]),
        .pin_out    (kbc_out_pin[gi]),
        .pin_oe     (kbc_out_pin_oe[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Isolation toward the controller
  // ------------------------------------------------------------------
  // Blocked lines read idle high so the controller sees no activity
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kbc_kbd_clock_in   <= 1'b1;
      kbc_kbd_data_in    <= 1'b1;
      kbc_mouse_clock_in <= 1'b1;
      kbc_mouse_data_in  <= 1'b1;
    end else begin
      kbc_kbd_clock_in   <= kra_q[KRA_KISO_BIT] | kck_s;
      kbc_kbd_data_in    <= kra_q[KRA_KISO_BIT] | kdt_s;
      kbc_mouse_clock_in <= kra_q[KRA_MISO_BIT] | mck_s;
      kbc_mouse_data_in  <= kra_q[KRA_MISO_BIT] | mdt_s;
    end
  end

  // ------------------------------------------------------------------
  // Wake detection
  // ------------------------------------------------------------------
  logic kdt_q;
  logic mdt_q;
  logic kdt_fall;
  logic mdt_fall;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kdt_q <= 1'b1;
      mdt_q <= 1'b1;
    end else begin
      kdt_q <= kdt_s;
      mdt_q <= mdt_s;
    end
  end

  // Taken ahead of isolation, so wake works while the controller is cut off
  assign kdt_fall = kdt_q & ~kdt_s;
  assign mdt_fall = mdt_q & ~mdt_s;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      kbd_wake_sts   <= 1'b0;
      mouse_wake_sts <= 1'b0;
    end else begin
      kbd_wake_sts   <= kdt_fall | (kbd_wake_sts & ~kbd_wake_sts_clr);
      mouse_wake_sts <= mdt_fall | (mouse_wake_sts & ~mouse_wake_sts_clr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= wake_global_enable &
                  ((kbd_wake_sts & kbd_wake_en) | (mouse_wake_sts & mouse_wake_en));
    end
  end

endmodule // fakg_glue
`default_nettype wire

// ### pkg/fakg_pkg.sv
// Constants for the fast A20 / reset / keyboard wake glue block
package fakg_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int ALT_RST_DELAY_NS  = 14000;
  localparam int ALT_RST_PULSE_NS  = 6000;
  localparam int PP_DRIVE_NS       = 500;
  // Least times round up, the push-pull drive window rounds down
  localparam int ALT_RST_DELAY_CYC = (ALT_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALT_RST_PULSE_CYC = (ALT_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PP_DRIVE_CYC      = (PP_DRIVE_NS / CLK_PERIOD_NS) < 1 ? 1
                                     : (PP_DRIVE_NS / CLK_PERIOD_NS);
  localparam int CNT_W             = 9;
  localparam int PP_CNT_W          = 4;

  // ------------------------------------------------------------------
  // Addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] FAST_PORT_ADDR  = 16'h0092;
  localparam logic [7:0]  CFG_IDX_KRA     = 8'hf0;
  localparam logic [7:0]  CFG_IDX_GLB2C   = 8'h2c;

  // ------------------------------------------------------------------
  // Fast port layout and reset values
  // ------------------------------------------------------------------
  localparam int          FP_RST_BIT      = 0;
  localparam int          FP_A20_BIT      = 1;
  localparam logic [7:0]  FP_FIXED_VAL    = 8'h24;
  localparam logic [7:0]  FP_RESET_VAL    = 8'h24;

  // ------------------------------------------------------------------
  // Config register layout
  // ------------------------------------------------------------------
  localparam int          KRA_PORT_EN_BIT = 2;
  localparam int          KRA_KLSEL_BIT   = 3;
  localparam int          KRA_MLSEL_BIT   = 4;
  localparam int          KRA_KISO_BIT    = 5;
  localparam int          KRA_MISO_BIT    = 6;
  localparam logic [7:0]  KRA_RESET_VAL   = 8'h00;
  localparam int          GLB_KBC_RST_BIT = 6;
  localparam logic [7:0]  GLB2C_RESET_VAL = 8'h00;

  // ------------------------------------------------------------------
  // Alternate reset sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    FAKG_ST_IDLE  = 4'b0001,
    FAKG_ST_DELAY = 4'b0010,
    FAKG_ST_PULSE = 4'b0100,
    FAKG_ST_DONE  = 4'b1000
  } fakg_rst_state_e;

endpackage : fakg_pkg

// ### logic/fakg_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fakg_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] d_sync
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      d_sync <= RST_VAL;
    end else begin
      meta_q <= d_async;
      d_sync <= meta_q;
    end
  end

endmodule // fakg_sync2
`default_nettype wire

// ### logic/fakg_pin_drv.sv
// Push-pull / open-drain driver for one controller output port bit
`timescale 1ns/1ps
`default_nettype none
module fakg_pin_drv
  import fakg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Controller side
  input  wire logic port_bit,
  input  wire logic open_drain,
  // Pin side
  output logic      pin_out,
  output logic      pin_oe
);

  logic                prev_q;
  logic [PP_CNT_W-1:0] drive_cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= port_bit;
    end
  end

  // High drive window after a 0-to-1 change, push-pull only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_cnt_q <= '0;
    end else if (!port_bit || open_drain) begin
      drive_cnt_q <= '0;
    end else if (!prev_q) begin
      drive_cnt_q <= PP_CNT_W'(PP_DRIVE_CYC);
    end else if (drive_cnt_q != '0) begin
      drive_cnt_q <= drive_cnt_q - 1'b1;
    end
  end

  // Pin floats at reset so the pull-up leaves it weak high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= port_bit;
      if (!port_bit) begin
        pin_oe <= 1'b1;
      end else if (!open_drain && (!prev_q || drive_cnt_q > PP_CNT_W'(1))) begin
        pin_oe <= 1'b1;
      end else begin
        pin_oe <= 1'b0;
      end
    end
  end

endmodule // fakg_pin_drv
`default_nettype wire

// ### verif/fakg_kbc_model.sv
// Keyboard controller core model driving the controller side of the glue
`timescale 1ns/1ps
`default_nettype none
module fakg_kbc_model (
  // Clock
  input  wire logic       clk_sys,
  // Controller outputs into the glue
  output logic            kbc_cpu_reset_n, kbc_a20_port_bit, gpio_polarity_inv,
  output logic            kbc_kbd_irq_raw, kbc_mouse_irq_raw, kbc_kbd_irq_clr, kbc_mouse_irq_clr,
  output logic      [2:0] kbc_out_bits, kbc_out_open_drain
);
  initial {kbc_cpu_reset_n, kbc_a20_port_bit, gpio_polarity_inv} = 3'b100;
  initial {kbc_kbd_irq_raw, kbc_mouse_irq_raw, kbc_kbd_irq_clr, kbc_mouse_irq_clr} = 4'h0;
  initial {kbc_out_bits, kbc_out_open_drain} = 6'h00;
  // All changes land on the falling edge, clear of the sampling edge
  task automatic ctl(input logic r, a, p);
    @(negedge clk_sys) {kbc_cpu_reset_n, kbc_a20_port_bit, gpio_polarity_inv} = {r, a, p};
  endtask
  task automatic pins(input logic [2:0] b, o);
    @(negedge clk_sys) {kbc_out_bits, kbc_out_open_drain} = {b, o};
  endtask
  task automatic irq(input logic k, m);
    @(negedge clk_sys) {kbc_kbd_irq_raw, kbc_mouse_irq_raw} = {k, m};
  endtask
  // Host read of the output buffer: request drops, latch clear is one cycle
  task automatic ack();
    @(negedge clk_sys) {kbc_kbd_irq_raw, kbc_mouse_irq_raw, kbc_kbd_irq_clr, kbc_mouse_irq_clr} = 4'h3;
    @(negedge clk_sys) {kbc_kbd_irq_clr, kbc_mouse_irq_clr} = 2'b00;
  endtask
endmodule // fakg_kbc_model
`default_nettype wire

// ### verif/fakg_glue_monitor.sv
// Port-level assertions for the fast A20 / reset glue block
`timescale 1ns/1ps
`default_nettype none
module fakg_glue_monitor
  import fakg_pkg::*;
(
  // Clock, reset and host side
  input wire logic       clk_sys, rst_n, io_rd_n, io_wr_n, io_rdata_oe,
  input wire logic [7:0] io_rdata,
  // A20 and reset paths
  input wire logic       gate_a, cpu_a20_mask_n, kbc_a20_port_bit, alt_cpu_reset_n,
  input wire logic       kbd_reset_out, kbc_cpu_reset_n, gpio_polarity_inv,
  // Irq, wake and pins
  input wire logic       kbd_irq, kbc_kbd_irq_raw, kbd_data_line, kbd_wake_sts,
  input wire logic       wake_req, wake_global_enable,
  input wire logic [2:0] kbc_out_pin, kbc_out_pin_oe, kbc_out_bits, kbc_out_open_drain
);
  logic [8:0] wr_age_q;
  logic [7:0] low_run_q;
  logic [3:0] pp_run_q;
  // Saturates so a long idle never wraps into a false short delay
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) wr_age_q <= 9'h000;
    else if ($fell(io_wr_n)) wr_age_q <= 9'h000;
    else if (wr_age_q != 9'h1ff) wr_age_q <= wr_age_q + 9'h001;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) low_run_q <= 8'h00;
    else low_run_q <= alt_cpu_reset_n ? 8'h00 : low_run_q + 8'h01;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) pp_run_q <= 4'h0;
    else pp_run_q <= (kbc_out_pin_oe[0] && kbc_out_pin[0]) ? pp_run_q + 4'h1 : 4'h0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rd_fixed; io_rdata_oe |-> (io_rdata & 8'hfc) == FP_FIXED_VAL; endproperty
  a_rd_fixed: assert property (p_rd_fixed) else $error("fixed bits wrong");
  property p_rd_idle; io_rd_n [*4] |-> !io_rdata_oe; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read drive without strobe");
  property p_mask_hi;
    $past(rst_n) |-> cpu_a20_mask_n == (gate_a || $past(kbc_a20_port_bit));
  endproperty
  a_mask_hi: assert property (p_mask_hi) else $error("a20 mask low");
  property p_rst_gap; $fell(alt_cpu_reset_n) |-> wr_age_q >= ALT_RST_DELAY_CYC; endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("reset pulse early");
  property p_rst_len; $rose(alt_cpu_reset_n) |-> low_run_q >= ALT_RST_PULSE_CYC; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
  property p_kbd_rst; !kbc_cpu_reset_n && !gpio_polarity_inv |=> !kbd_reset_out; endproperty
  a_kbd_rst: assert property (p_kbd_rst) else $error("kbd reset missed");
  property p_irq_src;
    $rose(kbd_irq) |-> $past(kbc_kbd_irq_raw) || $past(kbc_kbd_irq_raw, 2);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without source");
  property p_wake_set; $fell(kbd_data_line) |-> ##[1:6] kbd_wake_sts; endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake status missed");
  property p_wake_req; wake_req |-> $past(wake_global_enable); endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake without enable");
  property p_pp_win; pp_run_q <= PP_DRIVE_CYC; endproperty
  a_pp_win: assert property (p_pp_win) else $error("pin driven high too long");
  property p_od; (kbc_out_open_drain[0] && kbc_out_bits[0]) [*3] |-> !kbc_out_pin_oe[0]; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven");
  c_pulse: cover property ($fell(alt_cpu_reset_n));
  c_read: cover property ($rose(io_rdata_oe));
  c_wake: cover property ($rose(wake_req));
endmodule // fakg_glue_monitor
bind fakg_glue fakg_glue_monitor u_mon (.*);
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the fast A20 / reset glue block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fakg_pkg::*;
  logic clk_sys = 0, rst_n = 0, io_rd_n = 1, io_wr_n = 1, cfg_wr = 0, io_rdata_oe;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, cfg_index = 8'hf0, cfg_wdata = 8'h00, io_rdata, cfg_rdata;
  logic kbd_clock_line = 1, kbd_data_line = 1, mouse_clock_line = 1, mouse_data_line = 1;
  logic kbd_wake_en = 0, mouse_wake_en = 0, wake_global_enable = 0;
  logic kbd_wake_sts_clr = 0, mouse_wake_sts_clr = 0, kbd_wake_sts, mouse_wake_sts, wake_req;
  logic kbc_cpu_reset_n, kbc_a20_port_bit, kbc_kbd_irq_raw, kbc_mouse_irq_raw, kbc_hold_reset;
  logic kbc_kbd_irq_clr, kbc_mouse_irq_clr, gpio_polarity_inv, kbd_irq, mouse_irq;
  logic [2:0] kbc_out_bits, kbc_out_open_drain, kbc_out_pin, kbc_out_pin_oe, o;
  logic kbc_kbd_clock_in, kbc_kbd_data_in, kbc_mouse_clock_in, kbc_mouse_data_in;
  logic alt_cpu_reset_n, gate_a, cpu_a20_mask_n, kbd_reset_out;
  logic [8:0] rd;
  logic [7:0] fp_exp = 8'h24;
  int err_count = 0, tests_run = 0, n;

  fakg_glue DUT (.*);
  fakg_kbc_model kbc (.*);

  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d checks", s, tests_run);
  endtask
  task automatic cfg(input logic [7:0] i, d);
    @(negedge clk_sys) {cfg_index, cfg_wdata, cfg_wr} = {i, d, 1'b1};
    @(negedge clk_sys) cfg_wr = 0;
    chk("cfg", (i == 8'hf0 || i == 8'h2c) ? d : 8'h00, cfg_rdata);
  endtask
  // Strobe held five cycles, well past the sync delay, then released for four
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys) {io_addr, io_wdata} = {a, d};
    if (w) io_wr_n = 0;
    else io_rd_n = 0;
    cyc(5);
    rd = {io_rdata_oe, io_rdata};
    {io_wr_n, io_rd_n} = 2'b11;
    cyc(4);
    io_addr = 16'($urandom);
  endtask
  task automatic pulse(input logic e);
    int t0, t1, k;
    t0 = 9;
    t1 = 0;
    k = 0;
    chk("gate_a", fp_exp[1], gate_a);
    repeat (600) begin
      @(negedge clk_sys);
      t0 += (alt_cpu_reset_n && t1 == 0);
      t1 += !alt_cpu_reset_n;
      k += !kbd_reset_out;
    end
    chk("rst_len", e, t1 >= ALT_RST_PULSE_CYC);
    chk("rst_gap", e, e && t0 >= ALT_RST_DELAY_CYC);
    chk("rst_none", 0, !e && t1 != 0);
    chk("kbd_rst", 16'(t1), 16'(k));
  endtask
  task automatic wr92(input logic [7:0] d);
    logic e;
    e = !fp_exp[0] && d[0];
    fp_exp = 8'h24 | (d & 8'h03);
    io(1, FAST_PORT_ADDR, d);
    pulse(e);
  endtask
  task automatic rchk();
    cfg_index = 8'hf0;
    fp_exp = 8'h24;
    #1 chk("rst", 13'h1800, {alt_cpu_reset_n, kbd_reset_out, gate_a, cpu_a20_mask_n,
                            kbc_hold_reset, cfg_rdata});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(50 * 30000);
    err_count++;
    end_sim();
  end

  initial begin
    n = $urandom(31767);
    cyc(20);
    rst_n = 1;
    cyc(2);
    rchk();
    io(0, FAST_PORT_ADDR, 8'h00);
    chk("oe_off", 0, rd[8]);
    io(1, FAST_PORT_ADDR, 8'h03);
    pulse(0);
    cfg(8'hf0, 8'h04);
    cfg(8'h5a, 8'hff);
    io(0, 16'h0093, 8'h00);
    chk("oe_addr", 0, rd[8]);
    done("enable");
    for (n = 0; n < 4; n++) begin
      kbc.ctl(1, n[0], 0);
      wr92({6'($urandom), n[1], 1'b0});
      chk("mask", n[0] | n[1], cpu_a20_mask_n);
      io(0, FAST_PORT_ADDR, 8'($urandom));
      chk("port", {1'b1, fp_exp}, rd);
    end
    kbc.ctl(1, 0, 0);
    done("a20");
    wr92(8'h03);
    wr92(8'h03);
    wr92(8'h00);
    wr92(8'h01);
    @(negedge clk_sys) rst_n = 0;
    cyc(3);
    rst_n = 1;
    cyc(2);
    rchk();
    cfg(8'hf0, 8'h04);
    wr92(8'h01);
    done("alt_reset");
    for (n = 0; n < 4; n++) begin
      kbc.ctl(n[0], 0, n[1]);
      cyc(3);
      chk("kbd_pol", n[0] ^ n[1], kbd_reset_out);
    end
    kbc.ctl(1, 0, 1);
    for (n = 0; n < 3; n++) begin
      o = 3'($urandom);
      kbc.pins(3'b000, o);
      cyc(4);
      chk("pin_lo", 6'b111000, {kbc_out_pin_oe, kbc_out_pin});
      kbc.pins(3'b111, o);
      cyc(3);
      chk("pin_hi", {~o, ~o}, {kbc_out_pin_oe, kbc_out_pin & ~o});
      cyc(12);
      chk("pin_rel", 0, kbc_out_pin_oe);
    end
    kbc.ctl(1, 0, 0);
    done("pins");
    for (n = 0; n < 2; n++) begin
      cfg(8'hf0, {3'b000, n[0], n[0], 3'b100});
      kbc.irq(1, 1);
      cyc(3);
      chk("irq_on", 2'b11, {kbd_irq, mouse_irq});
      kbc.irq(0, 0);
      cyc(3);
      chk("irq_raw", {n[0], n[0]}, {kbd_irq, mouse_irq});
      kbc.ack();
      cyc(3);
      chk("irq_clr", 0, {kbd_irq, mouse_irq});
    end
    done("irq");
    cfg(8'hf0, 8'h64);
    {kbd_wake_en, mouse_wake_en} = 2'b11;
    {kbd_data_line, mouse_data_line, kbd_clock_line, mouse_clock_line} = 4'h0;
    cyc(8);
    chk("iso", 4'hf, {kbc_kbd_clock_in, kbc_kbd_data_in,
                      kbc_mouse_clock_in, kbc_mouse_data_in});
    chk("wake", 3'b110, {kbd_wake_sts, mouse_wake_sts, wake_req});
    wake_global_enable = 1;
    cyc(3);
    chk("wake_req", 1, wake_req);
    {kbd_data_line, mouse_data_line, kbd_wake_sts_clr, mouse_wake_sts_clr} = 4'hf;
    {kbd_clock_line, mouse_clock_line} = 2'b11;
    cyc(1);
    {kbd_wake_sts_clr, mouse_wake_sts_clr} = 2'b00;
    cfg(8'hf0, 8'h04);
    kbd_wake_en = 0;
    {kbd_data_line, kbd_clock_line} = 2'b00;
    cyc(8);
    chk("wake2", 5'b10000, {kbd_wake_sts, mouse_wake_sts, wake_req,
                            kbc_kbd_data_in, kbc_kbd_clock_in});
    done("wake");
    cfg(8'h2c, 8'h40);
    cyc(20);
    chk("hold", 1, kbc_hold_reset);
    cfg(8'h2c, 8'h00);
    cyc(1);
    chk("hold_off", 0, kbc_hold_reset);
    done("hold");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
